// ==== hdl/licw_pkg.sv ====
// constants shared by the inband alarm and control-word index register bank
package licw_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int IDX_W = 8;
	localparam int SEC_W = 3;
	localparam int NUM_ENTRIES = 256;
	localparam int NUM_SECTIONS = 5;
	localparam int TAB_DEPTH = NUM_ENTRIES * NUM_SECTIONS;
	localparam int TAB_AW = 11;

	localparam logic [ADDR_W-1:0] OFS_ALARM = 8'h2C;
	localparam logic [ADDR_W-1:0] OFS_INDEX = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_TX_DATA = 8'h34;
	localparam logic [ADDR_W-1:0] OFS_RX_DATA = 8'h38;

	localparam int BIT_LOCAL_LOF = 30;
	localparam int BIT_LOCAL_LOS = 29;
	localparam int BIT_REMOTE_LOF = 28;
	localparam int BIT_REMOTE_LOS = 27;
	localparam int BIT_REMOTE_SDI = 26;
	localparam int BIT_REMOTE_RAI = 25;
	localparam int BIT_RESET_SEEN = 24;
	localparam int BIT_SDI_GEN = 16;
	localparam int BIT_RAI_GEN = 8;
	localparam int BIT_RESET_GEN = 0;

	localparam int RX_SEC_LSB = 24;
	localparam int RX_IDX_LSB = 16;
	localparam int TX_INSERT_BIT = 11;
	localparam int TX_SEC_LSB = 8;
	localparam int TX_IDX_LSB = 0;

	localparam logic RST_SDI_GEN = 1'b0;
	localparam logic RST_RAI_GEN = 1'b1;
	localparam logic RST_RESET_GEN = 1'b0;
	localparam logic [IDX_W-1:0] RST_IDX = 8'h00;
	localparam logic [SEC_W-1:0] RST_SEC = 3'h0;
	localparam logic [SEC_W-1:0] LAST_SECTION = 3'h4;

	// flat table address of one 32-bit section; sections above the fifth are invalid
	function automatic logic [TAB_AW-1:0] table_addr(input logic [IDX_W-1:0] idx,
			input logic [SEC_W-1:0] sec);
		logic [TAB_AW-1:0] a;
		a = TAB_AW'(idx) * TAB_AW'(NUM_SECTIONS) + TAB_AW'(sec);
		return a;
	endfunction

	function automatic logic section_ok(input logic [SEC_W-1:0] sec);
		logic ok;
		ok = (sec <= LAST_SECTION);
		return ok;
	endfunction
endpackage

// ==== hdl/licw_table_if.sv ====
// signals between the register bank and its control-word tables
`timescale 1ns/100ps
interface licw_table_if;
	logic tx_wr;
	logic [10:0] tx_wr_addr;
	logic [31:0] tx_wr_data;
	logic ins_wr;
	logic [10:0] ins_wr_addr;
	logic ins_wr_data;
	logic [10:0] tx_rd_addr;
	logic tx_rd_ok;
	logic [31:0] tx_rd_data;
	logic ins_rd;
	logic [10:0] rx_rd_addr;
	logic rx_rd_ok;
	logic [31:0] rx_rd_data;
	logic rx_wr;
	logic [10:0] rx_wr_addr;
	logic [31:0] rx_wr_data;
	logic [10:0] slot_addr;
	logic [31:0] slot_data;
	logic slot_ins;

	modport ctrl (
		output tx_wr, tx_wr_addr, tx_wr_data, ins_wr, ins_wr_addr, ins_wr_data,
		output tx_rd_addr, tx_rd_ok, rx_rd_addr, rx_rd_ok, rx_wr, rx_wr_addr, rx_wr_data,
		output slot_addr,
		input tx_rd_data, ins_rd, rx_rd_data, slot_data, slot_ins
	);
	modport store (
		input tx_wr, tx_wr_addr, tx_wr_data, ins_wr, ins_wr_addr, ins_wr_data,
		input tx_rd_addr, tx_rd_ok, rx_rd_addr, rx_rd_ok, rx_wr, rx_wr_addr, rx_wr_data,
		input slot_addr,
		output tx_rd_data, ins_rd, rx_rd_data, slot_data, slot_ins
	);
endinterface // licw_table_if

// ==== hdl/licw_ctrl_table.sv ====
// receive and transmit control-word tables with per-section insert enables
`timescale 1ns/100ps
module licw_ctrl_table (
	input wire logic clk_i,
	input wire logic reset_n_i,
	licw_table_if.store tab
);
	logic [31:0] tx_mem [licw_pkg::TAB_DEPTH];
	logic [31:0] rx_mem [licw_pkg::TAB_DEPTH];
	logic ins_mem [licw_pkg::TAB_DEPTH];

	// transmit and receive table contents carry no reset so they can map onto block memory
	always_ff @(posedge clk_i) begin
		if (tab.tx_wr) begin
			tx_mem[tab.tx_wr_addr] <= tab.tx_wr_data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (tab.rx_wr) begin
			rx_mem[tab.rx_wr_addr] <= tab.rx_wr_data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < licw_pkg::TAB_DEPTH; i++) begin
				ins_mem[i] <= 1'b0;
			end
		end else if (tab.ins_wr) begin
			ins_mem[tab.ins_wr_addr] <= tab.ins_wr_data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			tab.tx_rd_data <= 32'h0;
			tab.rx_rd_data <= 32'h0;
			tab.ins_rd <= 1'b0;
			tab.slot_data <= 32'h0;
			tab.slot_ins <= 1'b0;
		end else begin
			tab.tx_rd_data <= tab.tx_rd_ok ? tx_mem[tab.tx_rd_addr] : 32'h0;
			tab.rx_rd_data <= tab.rx_rd_ok ? rx_mem[tab.rx_rd_addr] : 32'h0;
			tab.ins_rd <= tab.tx_rd_ok ? ins_mem[tab.tx_rd_addr] : 1'b0;
			tab.slot_data <= tx_mem[tab.slot_addr];
			tab.slot_ins <= ins_mem[tab.slot_addr];
		end
	end
endmodule // licw_ctrl_table

// ==== hdl/licw_top.sv ====
// inband layer-1 alarm word register and control-word index register bank
`timescale 1ns/100ps
module licw_top (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] cpu_address_i,
	input wire logic cpu_read_i,
	input wire logic cpu_write_i,
	input wire logic [31:0] cpu_writedata_i,
	output logic [31:0] cpu_readdata_o,
	output logic cpu_readdatavalid_o,
	input wire logic local_lof_i,
	input wire logic local_los_i,
	input wire logic remote_lof_i,
	input wire logic remote_los_i,
	input wire logic remote_sdi_i,
	input wire logic remote_rai_i,
	input wire logic remote_reset_req_i,
	input wire logic remote_reset_ack_i,
	output logic sdi_send_o,
	output logic rai_send_o,
	output logic reset_send_o,
	input wire logic rx_word_valid_i,
	input wire logic [7:0] rx_word_index_i,
	input wire logic [2:0] rx_word_section_i,
	input wire logic [31:0] rx_word_data_i,
	input wire logic insert_enable_i,
	input wire logic tx_slot_i,
	input wire logic [7:0] tx_slot_index_i,
	input wire logic [2:0] tx_slot_section_i,
	output logic tx_insert_o,
	output logic [31:0] tx_insert_data_o
);
	licw_table_if tab ();

	logic local_lof;
	logic local_los;
	logic remote_lof;
	logic remote_los;
	logic remote_sdi;
	logic remote_rai;
	logic reset_seen;
	logic sdi_gen;
	logic rai_gen;
	logic reset_gen;
	logic [2:0] receive_section_select;
	logic [7:0] rx_idx;
	logic [2:0] transmit_section_select;
	logic [7:0] tx_idx;
	logic rd_pend;
	logic [7:0] rd_addr;
	logic slot_pend;
	logic slot_ok_d;
	logic [31:0] next_readdata;
	logic wr_alarm;
	logic wr_index;
	logic wr_tx_data;
	logic [2:0] wr_tx_sec;
	logic [7:0] wr_tx_idx;
	logic tx_same_entry;

	assign wr_alarm = cpu_write_i && (cpu_address_i == licw_pkg::OFS_ALARM);
	assign wr_index = cpu_write_i && (cpu_address_i == licw_pkg::OFS_INDEX);
	assign wr_tx_data = cpu_write_i && (cpu_address_i == licw_pkg::OFS_TX_DATA);
	assign wr_tx_sec = cpu_writedata_i[licw_pkg::TX_SEC_LSB +: licw_pkg::SEC_W];
	assign wr_tx_idx = cpu_writedata_i[licw_pkg::TX_IDX_LSB +: licw_pkg::IDX_W];

	licw_ctrl_table i_licw_ctrl_table (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.tab(tab.store)
	);

	// link status is sampled every cycle so the register always shows the present condition
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			local_lof <= 1'b0;
			local_los <= 1'b0;
			remote_lof <= 1'b0;
			remote_los <= 1'b0;
			remote_sdi <= 1'b0;
			remote_rai <= 1'b0;
			reset_seen <= 1'b0;
		end else begin
			local_lof <= local_lof_i;
			local_los <= local_los_i;
			remote_lof <= remote_lof_i;
			remote_los <= remote_los_i;
			remote_sdi <= remote_sdi_i;
			remote_rai <= remote_rai_i;
			reset_seen <= remote_reset_req_i | remote_reset_ack_i;
		end
	end

	// generation enables; reserved write bits are dropped
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			sdi_gen <= licw_pkg::RST_SDI_GEN;
			rai_gen <= licw_pkg::RST_RAI_GEN;
			reset_gen <= licw_pkg::RST_RESET_GEN;
		end else if (wr_alarm) begin
			sdi_gen <= cpu_writedata_i[licw_pkg::BIT_SDI_GEN];
			rai_gen <= cpu_writedata_i[licw_pkg::BIT_RAI_GEN];
			reset_gen <= cpu_writedata_i[licw_pkg::BIT_RESET_GEN];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			sdi_send_o <= 1'b0;
			rai_send_o <= 1'b0;
			reset_send_o <= 1'b0;
		end else begin
			sdi_send_o <= sdi_gen;
			rai_send_o <= rai_gen & (local_los_i | local_lof_i);
			reset_send_o <= reset_gen;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			receive_section_select <= licw_pkg::RST_SEC;
			rx_idx <= licw_pkg::RST_IDX;
			transmit_section_select <= licw_pkg::RST_SEC;
			tx_idx <= licw_pkg::RST_IDX;
		end else if (wr_index) begin
			receive_section_select <= cpu_writedata_i[licw_pkg::RX_SEC_LSB +: licw_pkg::SEC_W];
			rx_idx <= cpu_writedata_i[licw_pkg::RX_IDX_LSB +: licw_pkg::IDX_W];
			transmit_section_select <= wr_tx_sec;
			tx_idx <= wr_tx_idx;
		end
	end

	// bit 11 is stored only by a write that keeps the addressed entry; a write that moves
	// the index or section only selects, so the new entry's stored enable shows untouched
	assign tx_same_entry = (wr_tx_idx == tx_idx) && (wr_tx_sec == transmit_section_select);
	assign tab.ins_wr = wr_index && tx_same_entry && licw_pkg::section_ok(wr_tx_sec);
	assign tab.ins_wr_addr = licw_pkg::table_addr(wr_tx_idx, wr_tx_sec);
	assign tab.ins_wr_data = cpu_writedata_i[licw_pkg::TX_INSERT_BIT];

	// writes to a sixth to eighth section have nowhere to go and are dropped
	assign tab.tx_wr = wr_tx_data && licw_pkg::section_ok(transmit_section_select);
	assign tab.tx_wr_addr = licw_pkg::table_addr(tx_idx, transmit_section_select);
	assign tab.tx_wr_data = cpu_writedata_i;
	assign tab.tx_rd_addr = licw_pkg::table_addr(tx_idx, transmit_section_select);
	assign tab.tx_rd_ok = licw_pkg::section_ok(transmit_section_select);
	assign tab.rx_rd_addr = licw_pkg::table_addr(rx_idx, receive_section_select);
	assign tab.rx_rd_ok = licw_pkg::section_ok(receive_section_select);

	assign tab.rx_wr = rx_word_valid_i && licw_pkg::section_ok(rx_word_section_i);
	assign tab.rx_wr_addr = licw_pkg::table_addr(rx_word_index_i, rx_word_section_i);
	assign tab.rx_wr_data = rx_word_data_i;
	assign tab.slot_addr = licw_pkg::table_addr(tx_slot_index_i, tx_slot_section_i);

	// table reads are registered, so the slot decision lands two edges after the slot
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			slot_pend <= 1'b0;
			slot_ok_d <= 1'b0;
			tx_insert_o <= 1'b0;
			tx_insert_data_o <= 32'h0;
		end else begin
			slot_pend <= tx_slot_i;
			slot_ok_d <= licw_pkg::section_ok(tx_slot_section_i);
			tx_insert_o <= slot_pend & slot_ok_d & tab.slot_ins & insert_enable_i;
			tx_insert_data_o <= tab.slot_data;
		end
	end

	// reads answer two edges later so the table lookup for the latest index can settle
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rd_pend <= 1'b0;
			rd_addr <= 8'h00;
		end else begin
			rd_pend <= cpu_read_i;
			rd_addr <= cpu_address_i;
		end
	end

	always_comb begin
		next_readdata = 32'h0;
		case (rd_addr)
			licw_pkg::OFS_ALARM: begin
				next_readdata[licw_pkg::BIT_LOCAL_LOF] = local_lof;
				next_readdata[licw_pkg::BIT_LOCAL_LOS] = local_los;
				next_readdata[licw_pkg::BIT_REMOTE_LOF] = remote_lof;
				next_readdata[licw_pkg::BIT_REMOTE_LOS] = remote_los;
				next_readdata[licw_pkg::BIT_REMOTE_SDI] = remote_sdi;
				next_readdata[licw_pkg::BIT_REMOTE_RAI] = remote_rai;
				next_readdata[licw_pkg::BIT_RESET_SEEN] = reset_seen;
				next_readdata[licw_pkg::BIT_SDI_GEN] = sdi_gen;
				next_readdata[licw_pkg::BIT_RAI_GEN] = rai_gen;
				next_readdata[licw_pkg::BIT_RESET_GEN] = reset_gen;
			end
			licw_pkg::OFS_INDEX: begin
				next_readdata[licw_pkg::RX_SEC_LSB +: licw_pkg::SEC_W] = receive_section_select;
				next_readdata[licw_pkg::RX_IDX_LSB +: licw_pkg::IDX_W] = rx_idx;
				next_readdata[licw_pkg::TX_INSERT_BIT] = tab.ins_rd;
				next_readdata[licw_pkg::TX_SEC_LSB +: licw_pkg::SEC_W] = transmit_section_select;
				next_readdata[licw_pkg::TX_IDX_LSB +: licw_pkg::IDX_W] = tx_idx;
			end
			licw_pkg::OFS_TX_DATA: begin
				next_readdata = tab.tx_rd_data;
			end
			licw_pkg::OFS_RX_DATA: begin
				next_readdata = tab.rx_rd_data;
			end
			default: begin
				next_readdata = 32'h0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			cpu_readdata_o <= 32'h0;
			cpu_readdatavalid_o <= 1'b0;
		end else begin
			cpu_readdata_o <= rd_pend ? next_readdata : 32'h0;
			cpu_readdatavalid_o <= rd_pend;
		end
	end
endmodule // licw_top

// ==== tb/licw_host.sv ====
// host model that reads and writes the register bank
`timescale 1ns/100ps
module licw_host (
	input wire logic clk_i,
	input wire logic [31:0] rdata_i,
	input wire logic rvalid_i,
	output logic [7:0] addr_o,
	output logic rd_o,
	output logic wr_o,
	output logic [31:0] wdata_o
);
	initial begin
		addr_o = 8'h00;
		rd_o = 1'b0;
		wr_o = 1'b0;
		wdata_o = 32'h0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i) #1;
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(posedge clk_i) #1;
		wr_o = 1'b0;
		// released lines must not keep showing the old value
		wdata_o = ~d;
		addr_o = ~a;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		d = 32'hXXXX_XXXX;
		@(posedge clk_i) #1;
		addr_o = a;
		rd_o = 1'b1;
		@(posedge clk_i) #1;
		rd_o = 1'b0;
		addr_o = ~a;
		// latency above one cycle is tolerated, but only for a bounded time
		for (int i = 0; i < 4; i++) begin
			@(negedge clk_i);
			if (rvalid_i === 1'b1) begin
				d = rdata_i;
				break;
			end
		end
		@(posedge clk_i) #1;
	endtask
endmodule // licw_host

// ==== tb/licw_checker.sv ====
// port assertions for the register bank
`timescale 1ns/100ps
module licw_checker (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] cpu_address_i,
	input wire logic cpu_read_i,
	input wire logic cpu_write_i,
	input wire logic [31:0] cpu_writedata_i,
	input wire logic [31:0] cpu_readdata_o,
	input wire logic cpu_readdatavalid_o,
	input wire logic local_lof_i,
	input wire logic local_los_i,
	input wire logic sdi_send_o,
	input wire logic rai_send_o,
	input wire logic reset_send_o,
	input wire logic tx_slot_i,
	input wire logic [2:0] tx_slot_section_i,
	input wire logic tx_insert_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	logic wa;
	assign wa = cpu_write_i && cpu_address_i == 8'h2C;
	property p_rd_lat;
		cpu_read_i |-> ##2 cpu_readdatavalid_o;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read not answered");
	property p_sdi;
		wa ##1 !wa |=> sdi_send_o == $past(cpu_writedata_i[16], 2);
	endproperty
	a_sdi: assert property (p_sdi) else $error("defect send wrong");
	property p_rst_gen;
		wa ##1 !wa |=> reset_send_o == $past(cpu_writedata_i[0], 2);
	endproperty
	a_rst_gen: assert property (p_rst_gen) else $error("reset send wrong");
	property p_rai;
		rai_send_o |-> $past(local_los_i || local_lof_i);
	endproperty
	a_rai: assert property (p_rai) else $error("alarm sent without loss");
	property p_ins;
		tx_insert_o |-> $past(tx_slot_i, 2) && $past(tx_slot_section_i, 2) <= 3'h4;
	endproperty
	a_ins: assert property (p_ins) else $error("insert without slot");
	property p_alarm_rsv;
		cpu_read_i && cpu_address_i == 8'h2C |-> ##2 (cpu_readdata_o & 32'h80FE_FEFE) == 32'h0;
	endproperty
	a_alarm_rsv: assert property (p_alarm_rsv) else $error("alarm reserved set");
	property p_idx_rsv;
		cpu_read_i && cpu_address_i == 8'h30 |-> ##2 (cpu_readdata_o & 32'hF800_F000) == 32'h0;
	endproperty
	a_idx_rsv: assert property (p_idx_rsv) else $error("index reserved set");
	property p_unmapped;
		cpu_read_i && cpu_address_i == 8'h3C |-> ##2 cpu_readdata_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
	property p_rst_out;
		$rose(reset_n_i) |-> !sdi_send_o && !reset_send_o && !tx_insert_o;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs set after reset");
	c_rd: cover property (cpu_readdatavalid_o);
	c_ins: cover property (tx_insert_o);
	c_rai: cover property (rai_send_o);
endmodule // licw_checker
bind licw_top licw_checker i_licw_checker (.clk_i, .reset_n_i, .cpu_address_i, .cpu_read_i,
	.cpu_write_i, .cpu_writedata_i, .cpu_readdata_o, .cpu_readdatavalid_o, .local_lof_i,
	.local_los_i, .sdi_send_o, .rai_send_o, .reset_send_o, .tx_slot_i, .tx_slot_section_i,
	.tx_insert_o);

// ==== tb/licw_top_test.sv ====
// self-checking bench for the alarm and index register bank
`timescale 1ns/100ps
module licw_top_test;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} licw_row_s;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [7:0] cpu_address_i;
	logic cpu_read_i;
	logic cpu_write_i;
	logic [31:0] cpu_writedata_i;
	logic [31:0] cpu_readdata_o;
	logic cpu_readdatavalid_o;
	logic local_lof_i, local_los_i, remote_lof_i, remote_los_i;
	logic remote_sdi_i, remote_rai_i, remote_reset_req_i, remote_reset_ack_i;
	logic sdi_send_o, rai_send_o, reset_send_o, tx_insert_o;
	logic rx_word_valid_i = 1'b0;
	logic [7:0] rx_word_index_i = 8'h00;
	logic [2:0] rx_word_section_i = 3'h0;
	logic [31:0] rx_word_data_i = 32'h0;
	logic insert_enable_i = 1'b0;
	logic tx_slot_i = 1'b0;
	logic [7:0] tx_slot_index_i = 8'h00;
	logic [2:0] tx_slot_section_i = 3'h0;
	logic [31:0] tx_insert_data_o;
	logic [7:0] st = 8'h00;
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	licw_row_s rows [10] = '{
		'{8'h2C, 32'hFFFF_FFFF, 32'h0001_0101},
		'{8'h2C, 32'h0000_0000, 32'h0000_0000},
		'{8'h30, 32'hFFFF_FFFF, 32'h07FF_07FF},
		'{8'h30, 32'h0000_0903, 32'h0000_0103},
		'{8'h30, 32'h0000_0903, 32'h0000_0903},
		'{8'h34, 32'hA5C3_0F96, 32'hA5C3_0F96},
		'{8'h30, 32'h0000_0004, 32'h0000_0004},
		'{8'h34, 32'h1234_5678, 32'h1234_5678},
		'{8'h30, 32'h0000_0103, 32'h0000_0903},
		'{8'h3C, 32'hFFFF_FFFF, 32'h0000_0000}};
	assign {local_lof_i, local_los_i, remote_lof_i, remote_los_i, remote_sdi_i, remote_rai_i,
		remote_reset_req_i, remote_reset_ack_i} = st;
	licw_top i_licw_top (.*);
	licw_host i_licw_host (.clk_i, .rdata_i(cpu_readdata_o), .rvalid_i(cpu_readdatavalid_o),
		.addr_o(cpu_address_i), .rd_o(cpu_read_i), .wr_o(cpu_write_i), .wdata_o(cpu_writedata_i));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	task automatic final_report();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 4000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		i_licw_host.rd(a, d);
		chk(d, e);
	endtask
	task automatic slot(input logic [7:0] x, input logic [2:0] s, input logic e);
		logic hit;
		hit = 1'b0;
		tx_slot_index_i = x;
		tx_slot_section_i = s;
		tx_slot_i = 1'b1;
		@(posedge clk_i) #1;
		tx_slot_i = 1'b0;
		repeat (3) begin
			@(negedge clk_i);
			if (tx_insert_o === 1'b1) begin
				hit = 1'b1;
				chk(tx_insert_data_o, 32'hA5C3_0F96);
			end
		end
		chk({31'h0, hit}, {31'h0, e});
		@(posedge clk_i) #1;
	endtask
	task automatic gens(input logic [31:0] e);
		repeat (3) @(posedge clk_i);
		#1 chk({29'h0, sdi_send_o, rai_send_o, reset_send_o}, e);
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		#1 reset_n_i = 1'b1;
		rc(8'h2C, 32'h0000_0100);
		rc(8'h30, 32'h0000_0000);
		gens(32'h0);
		foreach (rows[i]) begin
			i_licw_host.wr(rows[i].a, rows[i].d);
			rc(rows[i].a, rows[i].e);
		end
		for (int i = 0; i < 8; i++) begin
			st = 8'h80 >> i;
			rc(8'h2C, 32'h4000_0000 >> (i == 7 ? 6 : i));
		end
		st = 8'h40;
		i_licw_host.wr(8'h2C, 32'h0001_0101);
		gens(32'h7);
		i_licw_host.wr(8'h2C, 32'h0);
		gens(32'h0);
		st = 8'h00;
		rx_word_index_i = 8'h07;
		rx_word_section_i = 3'h4;
		rx_word_data_i = 32'h1111_2222;
		rx_word_valid_i = 1'b1;
		@(posedge clk_i) #1;
		rx_word_data_i = 32'h3333_4444;
		@(posedge clk_i) #1;
		rx_word_valid_i = 1'b0;
		rx_word_data_i = 32'hCCCC_BBBB;
		i_licw_host.wr(8'h30, 32'h0407_0000);
		rc(8'h38, 32'h3333_4444);
		insert_enable_i = 1'b1;
		slot(8'h03, 3'h1, 1'b1);
		slot(8'h04, 3'h0, 1'b0);
		insert_enable_i = 1'b0;
		slot(8'h03, 3'h1, 1'b0);
		// mid-run reset must restore the enables and clear the stored insert enable of index 3, section 1
		reset_n_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#1 reset_n_i = 1'b1;
		rc(8'h2C, 32'h0000_0100);
		i_licw_host.wr(8'h30, 32'h0000_0103);
		rc(8'h30, 32'h0000_0103);
		final_report();
	end
endmodule // licw_top_test
